// File: core/dcz_pkg.sv
package dcz_pkg;

  // register byte offsets on the plain register port
  localparam logic [7:0]  OFF_MAR_A      = 8'h20;
  localparam logic [7:0]  OFF_IOAR_A     = 8'h26;
  localparam logic [7:0]  OFF_CTL_A      = 8'h27;
  localparam logic [7:0]  OFF_MAR_B      = 8'h28;
  localparam logic [7:0]  OFF_IOAR_B     = 8'h2E;
  localparam logic [7:0]  OFF_CTL_B      = 8'h2F;
  localparam logic [7:0]  OFF_IRQ_STATUS = 8'h30;
  localparam logic [7:0]  OFF_IRQ_MASK   = 8'h31;

  // values after reset, and the read value of unmapped offsets
  localparam logic [7:0]  CTL_RESET      = 8'h00;
  localparam logic [7:0]  IOAR_RESET     = 8'h00;
  localparam logic [31:0] MAR_RESET      = 32'h00000000;
  localparam logic [1:0]  IRQ_RESET      = 2'h0;
  localparam logic [7:0]  READ_UNMAPPED  = 8'h00;

  // transfer control field positions (same positions in both address modes)
  localparam int BIT_ENABLE = 7;
  localparam int BIT_SIZE   = 6;
  localparam int BIT_DIR    = 5;
  localparam int BIT_RPT    = 4; // repeat enable (short) or step enable (full)
  localparam int BIT_IE     = 3; // end irq enable on side a, block-area select on side b in full mode
  localparam int BIT_BLOCK  = 0;

  localparam int SIDE_A = 0;
  localparam int SIDE_B = 1;

  // activation source codes, and the side-a bits 2:1 value that selects full mode
  localparam logic [2:0] SEL_TX         = 3'h4;
  localparam logic [2:0] SEL_RX         = 3'h5;
  localparam logic [2:0] SEL_EXT_FALL   = 3'h6;
  localparam logic [2:0] SEL_EXT_LOW    = 3'h7;
  localparam logic [2:0] SEL_AUTO_BURST = 3'h0;
  localparam logic [2:0] SEL_AUTO_STEAL = 3'h2;
  localparam logic [1:0] FULL_MODE_BITS = 2'h3;

  // address steps
  localparam logic [31:0] STEP_BYTE = 32'h00000001;
  localparam logic [31:0] STEP_WORD = 32'h00000002;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_BUSY = 2'h2
  } dcz_side_state_t;

  typedef struct packed {
    logic        full;
    logic        block;
    logic        block_src;
    logic        burst;
    logic        word;
    logic [31:0] mem_addr;
    logic [31:0] other_addr;
  } dcz_xfer_t;

endpackage

// File: core/dcz_addr_step.sv
// post-transfer address update: hold, increment or decrement by 1 or 2
module dcz_addr_step (
  input  wire logic        step_en,
  input  wire logic        dec,
  input  wire logic        word,
  input  wire logic [31:0] addr_in,
  output logic      [31:0] addr_out
);

  logic [31:0] step;

  // step size follows the transfer size
  always_comb begin
    step = word ? dcz_pkg::STEP_WORD : dcz_pkg::STEP_BYTE;
    if (!step_en) begin
      addr_out = addr_in;
    end else if (dec) begin
      addr_out = addr_in - step;
    end else begin
      addr_out = addr_in + step;
    end
  end

endmodule // dcz_addr_step

// File: core/dcz_dma_channel0_control.sv
// Overview of operation
// - In short address mode the 8-bit i/o address of a side is the other end of each transfer; full mode ignores it.
// - Short-mode source codes 000-011 pick timer channels 0-3, 100 serial transmit-empty, 101 serial receive-full.
// - Side-a control bits 2 and 1 both set select full address mode, where bit 0 picks normal or block transfer.
// - Side-b code 110 in short mode starts a transfer on each falling edge of the external request input.
// - Side-b code 111 in short mode requests transfers while the external request input is low.
// - The end interrupt enable bit gates the interrupt raised when the channel enable bit clears.
// - In short mode repeat enable 0 is i/o mode; with repeat enable 1, irq enable 0 is repeat and 1 is idle mode.
// - In short mode the memory address steps up (direction 0) or down (1) by 1 for bytes, 2 for words.
// - The channel enable bit disables transfers at 0 and enables them at 1 in short mode; full mode needs the enable bits of sides a and b both at 1.
// - In full mode the side-a address holds when its step enable is 0, else steps up or down by 1 or 2.
// - The side-b memory address is a 32-bit register reached as four bytes; its reset contents are undefined.
// - With the interrupt enable at 1 an interrupt request is raised once the channel enable bit has become 0.
// - In block mode the side-b mode bit makes the destination (0) or the source (1) the block area.
//
// Implementation choice: the plain strobed port.
module dcz_dma_channel0_control (
  input  wire logic              clk,
  input  wire logic              rstn,
  // register port
  input  wire logic [7:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata,
  // activation sources
  input  wire logic [3:0]        timer_match,
  input  wire logic              serial_tx_empty,
  input  wire logic              serial_rx_full,
  input  wire logic              external_request_n,
  // transfer handshake with the bus side
  output logic      [1:0]        xfer_req,
  input  wire logic [1:0]        xfer_ack,
  input  wire logic [1:0]        count_done,
  output dcz_pkg::dcz_xfer_t     xfer_cmd_a,
  output dcz_pkg::dcz_xfer_t     xfer_cmd_b,
  output logic                   irq
);

  logic [7:0]                 ctl_ff       [2];
  logic [7:0]                 ioar_ff      [2];
  logic [31:0]                mar_ff       [2];
  logic [31:0]                mar_start_ff [2];
  logic [31:0]                nxt_mar      [2];
  dcz_pkg::dcz_side_state_t   state_ff     [2];
  dcz_pkg::dcz_xfer_t         cmd_ff       [2];
  logic [1:0]                 status_ff;
  logic [1:0]                 mask_ff;
  logic                       ext_prev_ff;
  logic [7:0]                 nxt_rdata;

  logic        full_mode;
  logic        ext_fall;
  logic        ext_low;
  logic        full_hit;
  logic [1:0]  hit;
  logic [1:0]  active;
  logic [1:0]  launch;
  logic [1:0]  done;
  logic [1:0]  fin;
  logic [1:0]  step_go;
  logic [1:0]  step_en;
  logic [1:0]  step_word;
  logic [1:0]  reload;
  logic [1:0]  clr_enable;
  logic [1:0]  irq_event;
  logic [1:0]  wr_mar;

  // short-mode source decode, shared by both sides
  function automatic logic short_hit(input logic [2:0] sel, input logic side_b, input logic [3:0] tmr,
                                     input logic tx, input logic rx, input logic fall, input logic low);
    logic r;
    r = 1'b0;
    if (!sel[2]) begin
      r = tmr[sel[1:0]];
    end else if (sel == dcz_pkg::SEL_TX) begin
      r = tx;
    end else if (sel == dcz_pkg::SEL_RX) begin
      r = rx;
    end else if (side_b && sel == dcz_pkg::SEL_EXT_FALL) begin
      r = fall;
    end else if (side_b && sel == dcz_pkg::SEL_EXT_LOW) begin
      r = low;
    end
    return r;
  endfunction

  // byte k of a 32-bit address sits at base+k, most significant byte first
  function automatic logic [7:0] mar_byte(input logic [31:0] v, input logic [1:0] k);
    logic [7:0] b;
    b = v[8'(31 - 8 * k) -: 8];
    return b;
  endfunction

  function automatic logic is_mar(input logic [7:0] a, input logic [7:0] base);
    return a[7:2] == base[7:2];
  endfunction

  // falling edge of the external request; input is already synchronous
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ext_prev_ff <= 1'b1;
    end else begin
      ext_prev_ff <= external_request_n;
    end
  end

  assign ext_fall  = ext_prev_ff & ~external_request_n;
  assign ext_low   = ~external_request_n;
  assign full_mode = ctl_ff[dcz_pkg::SIDE_A][2:1] == dcz_pkg::FULL_MODE_BITS;

  // full-mode source decode from side-b select, split by normal/block
  always_comb begin
    full_hit = 1'b0;
    if (ctl_ff[dcz_pkg::SIDE_A][dcz_pkg::BIT_BLOCK]) begin
      if (!ctl_ff[dcz_pkg::SIDE_B][2]) begin
        full_hit = timer_match[ctl_ff[dcz_pkg::SIDE_B][1:0]];
      end else if (ctl_ff[dcz_pkg::SIDE_B][2:0] == dcz_pkg::SEL_EXT_FALL) begin
        full_hit = ext_fall;
      end
    end else begin
      unique case (ctl_ff[dcz_pkg::SIDE_B][2:0])
        dcz_pkg::SEL_AUTO_BURST, dcz_pkg::SEL_AUTO_STEAL: full_hit = 1'b1;
        dcz_pkg::SEL_EXT_FALL:                            full_hit = ext_fall;
        dcz_pkg::SEL_EXT_LOW:                             full_hit = ext_low;
        default:                                          full_hit = 1'b0; // codes marked not available
      endcase
    end
  end

  // per-side trigger and enable; side b has no engine of its own in full mode
  always_comb begin
    hit[dcz_pkg::SIDE_A] = full_mode ? full_hit :
                           short_hit(ctl_ff[dcz_pkg::SIDE_A][2:0], 1'b0, timer_match,
                                     serial_tx_empty, serial_rx_full, ext_fall, ext_low);
    hit[dcz_pkg::SIDE_B] = ~full_mode &
                           short_hit(ctl_ff[dcz_pkg::SIDE_B][2:0], 1'b1, timer_match,
                                     serial_tx_empty, serial_rx_full, ext_fall, ext_low);
    active[dcz_pkg::SIDE_A] = ctl_ff[dcz_pkg::SIDE_A][dcz_pkg::BIT_ENABLE] &
                              (~full_mode | ctl_ff[dcz_pkg::SIDE_B][dcz_pkg::BIT_ENABLE]);
    active[dcz_pkg::SIDE_B] = ~full_mode & ctl_ff[dcz_pkg::SIDE_B][dcz_pkg::BIT_ENABLE];
  end

  genvar s;
  generate
    for (s = 0; s < 2; s++) begin : g_side
      // request engine: one outstanding transfer per side
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          state_ff[s] <= dcz_pkg::ST_IDLE;
        end else begin
          unique case (state_ff[s])
            dcz_pkg::ST_IDLE: if (launch[s]) state_ff[s] <= dcz_pkg::ST_BUSY;
            dcz_pkg::ST_BUSY: if (xfer_ack[s]) state_ff[s] <= dcz_pkg::ST_IDLE;
          endcase
        end
      end

      assign launch[s]   = (state_ff[s] == dcz_pkg::ST_IDLE) & active[s] & hit[s];
      assign done[s]     = (state_ff[s] == dcz_pkg::ST_BUSY) & xfer_ack[s];
      assign fin[s]      = done[s] & count_done[s];
      assign xfer_req[s] = state_ff[s] == dcz_pkg::ST_BUSY;

      // command captured at launch so it stays stable while the request is pending
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          cmd_ff[s] <= '0;
        end else if (launch[s]) begin
          cmd_ff[s].full       <= full_mode;
          cmd_ff[s].block      <= full_mode & ctl_ff[dcz_pkg::SIDE_A][dcz_pkg::BIT_BLOCK];
          cmd_ff[s].block_src  <= full_mode & ctl_ff[dcz_pkg::SIDE_B][dcz_pkg::BIT_IE];
          cmd_ff[s].burst      <= full_mode & ~ctl_ff[dcz_pkg::SIDE_A][dcz_pkg::BIT_BLOCK] &
                                  (ctl_ff[dcz_pkg::SIDE_B][2:0] == dcz_pkg::SEL_AUTO_BURST);
          cmd_ff[s].word       <= ctl_ff[full_mode ? dcz_pkg::SIDE_A : s][dcz_pkg::BIT_SIZE];
          cmd_ff[s].mem_addr   <= mar_ff[s];
          cmd_ff[s].other_addr <= full_mode ? mar_ff[dcz_pkg::SIDE_B] : {24'h000000, ioar_ff[s]};
        end
      end

      // step controls; in full mode both addresses step on the side-a transfer, each only if its own step enable is 1
      always_comb begin
        if (full_mode) begin
          step_go[s]   = done[dcz_pkg::SIDE_A];
          step_en[s]   = ctl_ff[s][dcz_pkg::BIT_RPT];
          step_word[s] = ctl_ff[dcz_pkg::SIDE_A][dcz_pkg::BIT_SIZE];
          reload[s]    = 1'b0;
        end else begin
          step_go[s]   = done[s];
          // idle mode keeps the memory address fixed
          step_en[s]   = ~(ctl_ff[s][dcz_pkg::BIT_RPT] & ctl_ff[s][dcz_pkg::BIT_IE]);
          step_word[s] = ctl_ff[s][dcz_pkg::BIT_SIZE];
          reload[s]    = fin[s] & ctl_ff[s][dcz_pkg::BIT_RPT] & ~ctl_ff[s][dcz_pkg::BIT_IE];
        end
      end

      dcz_addr_step u_step (
        .step_en  (step_en[s]),
        .dec      (ctl_ff[s][dcz_pkg::BIT_DIR]),
        .word     (step_word[s]),
        .addr_in  (mar_ff[s]),
        .addr_out (nxt_mar[s])
      );

      assign wr_mar[s] = reg_wr & is_mar(reg_addr, s == 0 ? dcz_pkg::OFF_MAR_A : dcz_pkg::OFF_MAR_B);

      // memory address: software byte writes win over the hardware step
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          mar_ff[s]       <= dcz_pkg::MAR_RESET; // contents are not to be relied on
          mar_start_ff[s] <= dcz_pkg::MAR_RESET;
        end else if (wr_mar[s]) begin
          mar_ff[s][8'(31 - 8 * reg_addr[1:0]) -: 8]       <= reg_wdata;
          mar_start_ff[s][8'(31 - 8 * reg_addr[1:0]) -: 8] <= reg_wdata;
        end else if (reload[s]) begin
          mar_ff[s] <= mar_start_ff[s]; // repeat mode restarts from the programmed address
        end else if (step_go[s]) begin
          mar_ff[s] <= nxt_mar[s];
        end
      end

      // i/o address, used only in short mode
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          ioar_ff[s] <= dcz_pkg::IOAR_RESET;
        end else if (reg_wr && reg_addr == (s == 0 ? dcz_pkg::OFF_IOAR_A : dcz_pkg::OFF_IOAR_B)) begin
          ioar_ff[s] <= reg_wdata;
        end
      end
    end
  endgenerate

  // end of count clears the enable in i/o mode and, on side a only, always in full mode
  always_comb begin
    clr_enable[dcz_pkg::SIDE_A] = full_mode ? fin[dcz_pkg::SIDE_A] :
                                  fin[dcz_pkg::SIDE_A] & ~ctl_ff[dcz_pkg::SIDE_A][dcz_pkg::BIT_RPT];
    clr_enable[dcz_pkg::SIDE_B] = ~full_mode & fin[dcz_pkg::SIDE_B] &
                                  ~ctl_ff[dcz_pkg::SIDE_B][dcz_pkg::BIT_RPT];
    irq_event[dcz_pkg::SIDE_A]  = clr_enable[dcz_pkg::SIDE_A] & ctl_ff[dcz_pkg::SIDE_A][dcz_pkg::BIT_IE];
    irq_event[dcz_pkg::SIDE_B]  = clr_enable[dcz_pkg::SIDE_B] & ctl_ff[dcz_pkg::SIDE_B][dcz_pkg::BIT_IE];
  end

  // transfer control registers; a software write in the same cycle beats the hardware clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctl_ff[dcz_pkg::SIDE_A] <= dcz_pkg::CTL_RESET;
      ctl_ff[dcz_pkg::SIDE_B] <= dcz_pkg::CTL_RESET;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (reg_wr && reg_addr == (i == 0 ? dcz_pkg::OFF_CTL_A : dcz_pkg::OFF_CTL_B)) begin
          ctl_ff[i] <= reg_wdata;
        end else if (clr_enable[i]) begin
          ctl_ff[i][dcz_pkg::BIT_ENABLE] <= 1'b0;
        end
      end
    end
  end

  // sticky end status; reading clears, but a new event in that cycle survives
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      status_ff <= dcz_pkg::IRQ_RESET;
    end else if (reg_rd && reg_addr == dcz_pkg::OFF_IRQ_STATUS) begin
      status_ff <= irq_event;
    end else begin
      status_ff <= status_ff | irq_event;
    end
  end

  // interrupt mask, same layout as status
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mask_ff <= dcz_pkg::IRQ_RESET;
    end else if (reg_wr && reg_addr == dcz_pkg::OFF_IRQ_MASK) begin
      mask_ff <= reg_wdata[1:0];
    end
  end

  assign irq = |(status_ff & mask_ff);

  // read mux; unmapped offsets read as zero
  always_comb begin
    nxt_rdata = dcz_pkg::READ_UNMAPPED;
    if (is_mar(reg_addr, dcz_pkg::OFF_MAR_A)) begin
      nxt_rdata = mar_byte(mar_ff[dcz_pkg::SIDE_A], reg_addr[1:0]);
    end else if (is_mar(reg_addr, dcz_pkg::OFF_MAR_B)) begin
      nxt_rdata = mar_byte(mar_ff[dcz_pkg::SIDE_B], reg_addr[1:0]);
    end else begin
      unique case (reg_addr)
        dcz_pkg::OFF_IOAR_A:     nxt_rdata = ioar_ff[dcz_pkg::SIDE_A];
        dcz_pkg::OFF_CTL_A:      nxt_rdata = ctl_ff[dcz_pkg::SIDE_A];
        dcz_pkg::OFF_IOAR_B:     nxt_rdata = ioar_ff[dcz_pkg::SIDE_B];
        dcz_pkg::OFF_CTL_B:      nxt_rdata = ctl_ff[dcz_pkg::SIDE_B];
        dcz_pkg::OFF_IRQ_STATUS: nxt_rdata = {6'h00, status_ff};
        dcz_pkg::OFF_IRQ_MASK:   nxt_rdata = {6'h00, mask_ff};
        default:                 nxt_rdata = dcz_pkg::READ_UNMAPPED;
      endcase
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= nxt_rdata;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  assign xfer_cmd_a = cmd_ff[dcz_pkg::SIDE_A];
  assign xfer_cmd_b = cmd_ff[dcz_pkg::SIDE_B];

endmodule // dcz_dma_channel0_control

// File: verification/dcz_bus_side.sv
// bus-side partner: acknowledges each transfer request, promptly or after dly cycles
module dcz_bus_side (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic [1:0] xfer_req,
  input  wire logic [3:0] dly,
  input  wire logic       last,
  output logic      [1:0] xfer_ack,
  output logic      [1:0] count_done
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0][3:0] wait_ff;

  // one ack pulse per request; no second ack while the request is still falling away
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      xfer_ack <= 2'h0;
      wait_ff  <= 8'h00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        xfer_ack[i] <= xfer_req[i] && !xfer_ack[i] && wait_ff[i] == dly;
        wait_ff[i]  <= (xfer_req[i] && !xfer_ack[i] && wait_ff[i] != dly) ? wait_ff[i] + 4'h1 : 4'h0;
      end
    end
  end

  // end of count only ever travels with an ack
  assign count_done = xfer_ack & {2{last}};
endmodule // dcz_bus_side

// File: verification/dcz_chk.sv
module dcz_chk (
  input wire logic               clk,
  input wire logic               rstn,
  input wire logic [7:0]         reg_addr,
  input wire logic [7:0]         reg_wdata,
  input wire logic               reg_wr,
  input wire logic               reg_rd,
  input wire logic [7:0]         reg_rdata,
  input wire logic [1:0]         xfer_req,
  input wire logic [1:0]         xfer_ack,
  input wire logic [1:0]         count_done,
  input wire dcz_pkg::dcz_xfer_t xfer_cmd_a,
  input wire dcz_pkg::dcz_xfer_t xfer_cmd_b,
  input wire logic               irq
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       armed_ff;
  logic [1:0] mask_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // shadow of software writes; the mask is only ever changed by software
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      armed_ff <= 1'b0;
      mask_ff  <= 2'h0;
    end else if (reg_wr) begin
      if (reg_addr == dcz_pkg::OFF_CTL_A || reg_addr == dcz_pkg::OFF_CTL_B) armed_ff <= 1'b1;
      if (reg_addr == dcz_pkg::OFF_IRQ_MASK) mask_ff <= reg_wdata[1:0];
    end
  end

  a_rdata_one_cycle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside its cycle");
  a_quiet_until_prog: assert property (!armed_ff |-> xfer_req == 2'h0 && !irq)
    else $error("activity before the channel was programmed");
  a_req_held_a: assert property (xfer_req[0] && !xfer_ack[0] |=> xfer_req[0])
    else $error("side a request dropped before ack");
  a_ack_ends_b: assert property (xfer_req[1] && xfer_ack[1] |=> !xfer_req[1])
    else $error("side b request stays after ack");
  a_cmd_a_stable: assert property (xfer_req[0] && !xfer_ack[0] |=> $stable(xfer_cmd_a))
    else $error("side a command moved during transfer");
  a_cmd_b_stable: assert property (xfer_req[1] ##1 xfer_req[1] |-> $stable(xfer_cmd_b))
    else $error("side b command moved during transfer");
  a_irq_cause: assert property ($rose(irq) |-> $past(|(xfer_ack & count_done)) || $past(reg_wr))
    else $error("irq rose without an end of transfer");
  a_irq_masked: assert property (irq |-> mask_ff != 2'h0)
    else $error("irq with every source masked");
  a_status_clear: assert property (reg_rd && reg_addr == dcz_pkg::OFF_IRQ_STATUS && xfer_ack == 2'h0 |=> !irq)
    else $error("status read left irq high");

  c_irq: cover property ($rose(irq));
  c_end: cover property (|(xfer_ack & count_done));
  c_side_b: cover property ($rose(xfer_req[1]));
endmodule // dcz_chk

bind dcz_dma_channel0_control dcz_chk u_chk (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .xfer_req(xfer_req),
  .xfer_ack(xfer_ack), .count_done(count_done), .xfer_cmd_a(xfer_cmd_a), .xfer_cmd_b(xfer_cmd_b), .irq(irq));

// File: verification/dcz_tb.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] CTLA = dcz_pkg::OFF_CTL_A;
  localparam logic [7:0] CTLB = dcz_pkg::OFF_CTL_B;
  localparam logic [7:0] STAT = dcz_pkg::OFF_IRQ_STATUS;
  logic               clk                = 1'b0;
  logic               rstn               = 1'b0;
  logic [7:0]         reg_addr           = 8'h00;
  logic [7:0]         reg_wdata          = 8'h00;
  logic               reg_wr             = 1'b0;
  logic               reg_rd             = 1'b0;
  logic [3:0]         timer_match        = 4'h0;
  logic               serial_tx_empty    = 1'b0;
  logic               serial_rx_full     = 1'b0;
  logic               external_request_n = 1'b1;
  logic               last               = 1'b0;
  logic [3:0]         dly                = 4'h0;
  logic [7:0]         reg_rdata;
  logic [1:0]         xfer_req;
  logic [1:0]         xfer_ack;
  logic [1:0]         count_done;
  logic               irq;
  dcz_pkg::dcz_xfer_t xfer_cmd_a;
  dcz_pkg::dcz_xfer_t xfer_cmd_b;
  dcz_pkg::dcz_xfer_t cmd;
  int                 err_count          = 0;
  int                 n_tests            = 0;

  // free-running system clock
  always #25 clk = ~clk;

  dcz_dma_channel0_control dut (.clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .timer_match, .serial_tx_empty, .serial_rx_full, .external_request_n, .xfer_req, .xfer_ack,
    .count_done, .xfer_cmd_a, .xfer_cmd_b, .irq);
  dcz_bus_side bus (.clk, .rstn, .xfer_req, .dly, .last, .xfer_ack, .count_done);

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask

  // strobes are one cycle; the gap before the next access keeps each strobe assigned once per step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp, what);
  endtask

  task automatic wmar(input logic [31:0] a);
    for (int i = 0; i < 4; i++) wr(dcz_pkg::OFF_MAR_A + 8'(i), a[31 - 8 * i -: 8]);
  endtask

  // one-cycle pulse on activation source c: 0..3 timers, 4 transmit empty, 5 receive full
  task automatic fire(input int c);
    @(posedge clk);
    timer_match     <= (c < 4) ? 4'h1 << c : 4'h0;
    serial_tx_empty <= (c == 4);
    serial_rx_full  <= (c == 5);
    @(posedge clk);
    timer_match     <= 4'h0;
    serial_tx_empty <= 1'b0;
    serial_rx_full  <= 1'b0;
  endtask

  // bounded wait for a launch on side s, then for the request to drain
  task automatic xwait(input int s, input logic exp, input string what);
    logic seen;
    seen = 1'b0;
    for (int i = 0; i < 12 && !seen; i++) begin
      @(posedge clk);
      #1 seen = xfer_req[s];
    end
    cmd = s ? xfer_cmd_b : xfer_cmd_a;
    chk(seen, exp, what);
    for (int i = 0; i < 20 && xfer_req[s] !== 1'b0; i++) begin
      @(posedge clk);
      #1;
    end
    if (xfer_req[s] !== 1'b0) begin
      err_count++;
      test_done();
    end
  endtask

  task automatic t_regs;
    rdc(CTLA, 8'h00, "ctl a reset");
    rdc(CTLB, 8'h00, "ctl b reset");
    wr(dcz_pkg::OFF_IOAR_A, 8'hA5);
    wr(dcz_pkg::OFF_IOAR_B, 8'h5A);
    wr(8'h3F, 8'hFF);
    for (int i = 0; i < 4; i++) wr(dcz_pkg::OFF_MAR_B + 8'(i), 8'h11 * 8'(i + 1));
    rdc(dcz_pkg::OFF_IOAR_A, 8'hA5, "io address a");
    rdc(dcz_pkg::OFF_IOAR_B, 8'h5A, "io address b");
    rdc(8'h3F, dcz_pkg::READ_UNMAPPED, "unmapped read");
    for (int i = 0; i < 4; i++) rdc(dcz_pkg::OFF_MAR_B + 8'(i), 8'h11 * 8'(i + 1), "mem addr b");
    $display("register test done");
  endtask

  // each code answers its own source and ignores a neighbouring one
  task automatic t_src;
    for (int c = 0; c < 6; c++) begin
      wr(CTLA, 8'h80 | 8'(c));
      fire((c + 1) % 6);
      xwait(0, 1'b0, "wrong source launched");
      fire(c);
      xwait(0, 1'b1, "source missed");
      chk(cmd.other_addr, 32'h000000A5, "io address end");
    end
    $display("source test done");
  endtask

  task automatic t_step;
    logic [31:0] step;
    for (int k = 0; k < 4; k++) begin
      step = k[1] ? dcz_pkg::STEP_WORD : dcz_pkg::STEP_BYTE;
      wmar(32'h00000100);
      wr(CTLA, {1'b1, k[1], k[0], 5'h00});
      fire(0);
      xwait(0, 1'b1, "step launch");
      fire(0);
      xwait(0, 1'b1, "step relaunch");
      chk(cmd.mem_addr, k[0] ? 32'h00000100 - step : 32'h00000100 + step, "stepped address");
      chk(cmd.word, k[1], "size");
    end
    $display("address step test done");
  endtask

  // repeat reloads, i/o mode ends and disables, idle holds the address
  task automatic t_mode;
    last <= 1'b1;
    wmar(32'h00000200);
    wr(CTLA, 8'h90);
    fire(0);
    xwait(0, 1'b1, "repeat launch");
    rdc(CTLA, 8'h90, "repeat keeps enable");
    fire(0);
    xwait(0, 1'b1, "repeat relaunch");
    chk(cmd.mem_addr, 32'h00000200, "repeat reload");
    wr(CTLA, 8'h80);
    fire(0);
    xwait(0, 1'b1, "io launch");
    rdc(CTLA, 8'h00, "io end clears enable");
    rdc(STAT, 8'h00, "status with irq off");
    fire(0);
    xwait(0, 1'b0, "disabled launched");
    last <= 1'b0;
    wr(CTLA, 8'h98);
    fire(0);
    xwait(0, 1'b1, "idle launch");
    fire(0);
    xwait(0, 1'b1, "idle relaunch");
    chk(cmd.mem_addr, 32'h00000201, "idle address fixed");
    $display("mode test done");
  endtask

  task automatic t_irq;
    wr(dcz_pkg::OFF_IRQ_MASK, 8'h01);
    last <= 1'b1;
    wr(CTLA, 8'h88);
    fire(0);
    xwait(0, 1'b1, "irq launch");
    chk(irq, 1'b1, "end irq");
    rdc(CTLA, 8'h08, "end clears enable");
    rdc(STAT, 8'h01, "status set");
    chk(irq, 1'b0, "read clears irq");
    wr(dcz_pkg::OFF_IRQ_MASK, 8'h00);
    wr(CTLA, 8'h88);
    fire(0);
    xwait(0, 1'b1, "masked launch");
    chk(irq, 1'b0, "masked irq");
    rdc(STAT, 8'h01, "masked status");
    last <= 1'b0;
    $display("interrupt test done");
  endtask

  task automatic t_ext;
    wr(CTLB, 8'h86);
    xwait(1, 1'b0, "launch without edge");
    @(posedge clk);
    external_request_n <= 1'b0;
    xwait(1, 1'b1, "falling edge launch");
    chk(cmd.mem_addr, 32'h11223344, "side b address");
    chk(cmd.other_addr, 32'h0000005A, "io address b end");
    xwait(1, 1'b0, "held low relaunched");
    @(posedge clk);
    external_request_n <= 1'b1;
    wr(CTLB, 8'h87);
    @(posedge clk);
    external_request_n <= 1'b0;
    xwait(1, 1'b1, "low level launch");
    xwait(1, 1'b1, "low level relaunch");
    @(posedge clk);
    external_request_n <= 1'b1;
    wr(CTLB, 8'h00);
    $display("external request test done");
  endtask

  // full mode with a slow bus side: auto request, then timer-driven block transfers
  task automatic t_full;
    dly  <= 4'h3;
    last <= 1'b1;
    wr(CTLA, 8'h00);
    wmar(32'h00000300);
    wr(CTLB, 8'h80);
    wr(CTLA, 8'h86);
    xwait(0, 1'b1, "auto request launch");
    chk({cmd.full, cmd.block, cmd.burst}, 3'h5, "full normal burst");
    rdc(CTLA, 8'h06, "full end clears enable");
    last <= 1'b0;
    wr(CTLB, 8'h88);
    wr(CTLA, 8'h97);
    xwait(0, 1'b0, "block without timer");
    fire(0);
    xwait(0, 1'b1, "block launch");
    chk(cmd.mem_addr, 32'h00000300, "held address");
    chk({cmd.block, cmd.block_src}, 2'h3, "source is block area");
    fire(0);
    xwait(0, 1'b1, "block relaunch");
    chk(cmd.mem_addr, 32'h00000301, "stepped address");
    wr(CTLA, 8'h00);
    wr(CTLB, 8'h00);
    $display("full mode test done");
  endtask

  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    t_src();
    t_step();
    t_mode();
    t_irq();
    t_ext();
    t_full();
    test_done();
  end
endmodule // testbench
